// ===== design/clock_select_pkg.sv
/*
 * Shared constants and types of the oscillator select and clock divider block:
 * register offsets, field positions, reset values, source codes and carriers.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package clock_select_pkg;

	localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLK_DIV = 8'h04;
	localparam logic [7:0] OFS_PLL_FBD = 8'h08;
	localparam logic [7:0] OFS_UNLOCK = 8'h0C;

	localparam logic [15:0] UNLOCK_KEY_A = 16'h005A;
	localparam logic [15:0] UNLOCK_KEY_B = 16'h00A5;

	// oscillator control fields
	localparam int OSC_CUR_LSB = 12;
	localparam int OSC_NEW_LSB = 8;
	localparam int OSC_LOCK_BIT = 7;
	localparam int OSC_PLL_LOCKED_BIT = 5;
	localparam int OSC_FAIL_BIT = 3;
	localparam int OSC_SEC_EN_BIT = 1;
	localparam int OSC_SWITCH_BIT = 0;

	// clock divisor fields
	localparam int DIV_ROI_BIT = 15;
	localparam int DIV_DOZE_LSB = 12;
	localparam int DIV_REDUCTION_ENABLE_BIT = 11;
	localparam int DIV_RC_LSB = 8;
	localparam int DIV_POST_LSB = 6;
	localparam int DIV_PRE_LSB = 0;

	localparam logic [2:0] DOZE_RESET = 3'h3;
	localparam logic [2:0] RC_DIV_RESET = 3'h0;
	localparam logic [1:0] POST_RESET = 2'h1;
	localparam logic [1:0] POST_RESERVED = 2'h2;
	localparam logic [4:0] PRE_RESET = 5'h00;
	localparam logic [8:0] FBD_RESET = 9'h030;
	localparam logic [2:0] RC_DIV_MAX_CODE = 3'h7;
	localparam logic [8:0] RC_DIV_MAX_SHIFT = 9'h008;

	localparam logic [5:0] PRE_OFFSET = 6'h02;
	localparam logic [9:0] FBD_OFFSET = 10'h002;
	localparam logic [3:0] SWITCH_WAIT_TICKS = 4'hA;
	localparam logic [1:0] CORE_DIVIDE = 2'h2;

	typedef enum logic [2:0] {
		SRC_FAST_RC = 3'b000,
		SRC_FAST_RC_PLL = 3'b001,
		SRC_PRIMARY = 3'b010,
		SRC_PRIMARY_PLL = 3'b011,
		SRC_SECONDARY = 3'b100,
		SRC_LOW_POWER_RC = 3'b101,
		SRC_FAST_RC_DIV16 = 3'b110,
		SRC_FAST_RC_DIV_N = 3'b111
	} source_e;

	typedef enum logic [1:0] {
		PRIM_EXT_CLOCK = 2'b00,
		PRIM_CRYSTAL = 2'b01,
		PRIM_HS_CRYSTAL = 2'b10,
		PRIM_NONE = 2'b11
	} primary_e;

	typedef struct packed {
		logic [5:0] in_divide;
		logic [9:0] feedback_mult;
		logic [3:0] out_divide;
	} pll_cfg_s;

	typedef struct packed {
		logic [2:0] initial_source_cfg;
		logic [1:0] primary_submode_cfg;
		logic switch_disable_cfg;
		logic switch_monitor_cfg_low;
		logic osc_pin_function_cfg;
	} cfg_bits_s;

endpackage : clock_select_pkg

// ===== design/clock_select.sv
/*
 * Oscillator select and clock divider: control/divisor/feedback registers over
 * AXI4-Lite, clock switch sequencer, glitch-free core, peripheral and rc enables.
 * Assumes aclk is the oscillator output, oscillator status pins are asynchronous,
 * configuration bits are stable around power-on reset, aresetn is power-on reset.
 */
// Function
// - primary submode from 2-bit config: 10 hs crystal, 01 crystal, 00 external.
// - 3-bit source code maps eight sources, rc, pll, primary, secondary, low-power.
// - unprogrammed config 111 starts on fast rc with divide-by-n.
// - second oscillator pin function comes from its own config bit.
// - read-only bits 14-12 report the source in use.
// - writable bits 10-8 hold requested source, loaded at power-on from config.
// - lock bit 7 with monitor config 1 blocks clock and pll changes.
// - bit 5 reads 1 when pll locked and a pll source is in use, else 0.
// - bit 3 set by clock failure, software reads and clears only.
// - control register writes ignored unless preceded by unlock sequence.
// - registers reset only by power-on reset.
// - bit 1 enables the secondary oscillator.
// - writing bit 0 requests switch, hardware clears it when done.
// - recover-on-interrupt lets any interrupt clear doze enable.
// - doze field bits 14-12 divides processor clock by 2^value, default 8.
// - doze enable applies ratio, cleared forces ratio one.
// - rc postscaler bits 10-8 divides 1..64, code 111 divides 256.
// - pll output divider bits 7-6: 2, 4, 8; code 10 reserved.
// - pll input divider bits 4-0 is value plus two.
// - instruction and peripheral clock is oscillator divided by two.
// - pll output is input times feedback factor over pre and post factors.
// - switch to same source clears request and aborts.
// - after new source ready, wait 10 new clock cycles, then switch.
`timescale 1ns/1ps

module clock_select (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire clock_select_pkg::cfg_bits_s cfg_bits,
	input wire logic [7:0] source_ready,
	input wire logic new_source_clk,
	input wire logic pll_locked_pin,
	input wire logic clock_fail_pin,
	input wire logic interrupt_event,
	output logic [2:0] current_source_sel,
	output clock_select_pkg::primary_e primary_mode,
	output logic osc_pin_is_io,
	output logic secondary_osc_enable,
	output logic pll_enable,
	output clock_select_pkg::pll_cfg_s pll_cfg,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic rc_div_clk_en
);

	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_WAIT_READY = 2'b01,
		SW_COUNT = 2'b10
	} switch_e;

	// oscillator control state
	logic [2:0] cur_src_q;
	logic [2:0] new_src_q;
	logic cfg_lock_q;
	logic fail_q;
	logic sec_en_q;
	logic switch_q;
	logic cfg_load_q;
	clock_select_pkg::cfg_bits_s cfg_q;
	// divisor state
	logic roi_q;
	logic [2:0] doze_q;
	logic reduction_enable_q;
	logic [2:0] rc_div_q;
	logic [1:0] post_q;
	logic [4:0] pre_q;
	logic [8:0] fbd_q;
	logic [1:0] unlock_q;

	// bus slave state
	logic aw_full_q;
	logic w_full_q;
	logic [7:0] waddr_q;
	logic [15:0] wdata_q;
	logic [1:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// async pins: three flops, change taken when second and third agree
	logic [2:0] clk_sync_q;
	logic [2:0] lock_sync_q;
	logic [2:0] fail_sync_q;
	logic [7:0] rdy_sync1_q;
	logic [7:0] rdy_sync2_q;
	logic [7:0] rdy_sync3_q;
	logic clk_filt_q;
	logic lock_filt_q;
	logic fail_filt_q;
	logic [7:0] rdy_filt_q;

	switch_e sw_state_q;
	switch_e sw_state_d;
	logic [3:0] tick_cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_sync_q <= '0;
			lock_sync_q <= '0;
			fail_sync_q <= '0;
			rdy_sync1_q <= '0;
			rdy_sync2_q <= '0;
			rdy_sync3_q <= '0;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], new_source_clk};
			lock_sync_q <= {lock_sync_q[1:0], pll_locked_pin};
			fail_sync_q <= {fail_sync_q[1:0], clock_fail_pin};
			rdy_sync1_q <= source_ready;
			rdy_sync2_q <= rdy_sync1_q;
			rdy_sync3_q <= rdy_sync2_q;
		end
	end

	wire clk_agree = clk_sync_q[1] == clk_sync_q[2];
	wire lock_agree = lock_sync_q[1] == lock_sync_q[2];
	wire fail_agree = fail_sync_q[1] == fail_sync_q[2];
	wire [7:0] rdy_agree = ~(rdy_sync2_q ^ rdy_sync3_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_filt_q <= 1'b0;
			lock_filt_q <= 1'b0;
			fail_filt_q <= 1'b0;
			rdy_filt_q <= '0;
		end else begin
			clk_filt_q <= clk_agree ? clk_sync_q[2] : clk_filt_q;
			lock_filt_q <= lock_agree ? lock_sync_q[2] : lock_filt_q;
			fail_filt_q <= fail_agree ? fail_sync_q[2] : fail_filt_q;
			rdy_filt_q <= (rdy_agree & rdy_sync3_q) | (~rdy_agree & rdy_filt_q);
		end
	end

	wire new_clk_rise = clk_agree && clk_sync_q[2] && !clk_filt_q;
	wire fail_rise = fail_agree && fail_sync_q[2] && !fail_filt_q;

	// AXI4-Lite write path: address and data taken in either order
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	wire wr_go = aw_full_q && w_full_q && !bvalid_q;
	wire wr_osc = wr_go && waddr_q == clock_select_pkg::OFS_OSC_CTRL;
	wire wr_div = wr_go && waddr_q == clock_select_pkg::OFS_CLK_DIV;
	wire wr_fbd = wr_go && waddr_q == clock_select_pkg::OFS_PLL_FBD;
	wire wr_key = wr_go && waddr_q == clock_select_pkg::OFS_UNLOCK;
	wire wr_mapped = wr_osc || wr_div || wr_fbd || wr_key;
	wire unlocked = unlock_q[1];
	wire osc_hi_wr = wr_osc && unlocked && wstrb_q[1];
	wire osc_lo_wr = wr_osc && unlocked && wstrb_q[0];
	wire cfg_locked = cfg_lock_q && cfg_q.switch_monitor_cfg_low;
	wire switching_on = !cfg_q.switch_disable_cfg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				waddr_q <= |s_axi_awaddr[31:8] ? 8'hFF : s_axi_awaddr[7:0] & 8'hFC;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata[15:0];
				wstrb_q <= s_axi_wstrb[1:0];
			end
			if (wr_go) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				// unmapped offsets answer with a decode error
				bresp_q <= wr_mapped ? 2'b00 : 2'b11;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// register read images
	wire pll_src = cur_src_q == clock_select_pkg::SRC_PRIMARY_PLL
		|| cur_src_q == clock_select_pkg::SRC_FAST_RC_PLL;
	wire pll_locked_bit = pll_src && lock_filt_q;
	wire [15:0] osc_img = {1'b0, cur_src_q, 1'b0, new_src_q, cfg_lock_q, 1'b0,
		pll_locked_bit, 1'b0, fail_q, 1'b0, sec_en_q, switch_q};
	wire [15:0] div_img = {roi_q, doze_q, reduction_enable_q, rc_div_q, post_q, 1'b0, pre_q};
	wire [7:0] raddr = s_axi_araddr[7:0] & 8'hFC;
	wire rd_hit_hi = s_axi_araddr[31:8] == 24'h000000;
	wire rd_osc = rd_hit_hi && raddr == clock_select_pkg::OFS_OSC_CTRL;
	wire rd_div = rd_hit_hi && raddr == clock_select_pkg::OFS_CLK_DIV;
	wire rd_fbd = rd_hit_hi && raddr == clock_select_pkg::OFS_PLL_FBD;
	wire rd_key = rd_hit_hi && raddr == clock_select_pkg::OFS_UNLOCK;
	wire [15:0] rd_word = rd_osc ? osc_img : rd_div ? div_img : rd_fbd ? {7'h00, fbd_q} : 16'h0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= {16'h0000, rd_word};
			rresp_q <= (rd_osc || rd_div || rd_fbd || rd_key) ? 2'b00 : 2'b11;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// unlock: key a then key b arms one control write; any other write disarms
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unlock_q <= 2'b00;
		end else if (wr_key && wdata_q == clock_select_pkg::UNLOCK_KEY_A) begin
			unlock_q <= 2'b01;
		end else if (wr_key && wdata_q == clock_select_pkg::UNLOCK_KEY_B && unlock_q[0]) begin
			unlock_q <= 2'b10;
		end else if (wr_go) begin
			unlock_q <= 2'b00;
		end
	end

	// switch sequencer
	wire req_same = new_src_q == cur_src_q;
	wire new_is_pll = new_src_q == clock_select_pkg::SRC_PRIMARY_PLL
		|| new_src_q == clock_select_pkg::SRC_FAST_RC_PLL;
	wire new_ready = rdy_filt_q[new_src_q] && (!new_is_pll || lock_filt_q);
	wire sw_start = sw_state_q == SW_IDLE && switch_q && switching_on;
	wire sw_abort = sw_start && req_same;
	wire sw_done = sw_state_q == SW_COUNT && new_clk_rise
		&& tick_cnt_q == clock_select_pkg::SWITCH_WAIT_TICKS - 4'h1;

	always_comb begin
		sw_state_d = sw_state_q;
		case (sw_state_q)
			SW_IDLE: begin
				if (sw_start && !req_same) begin
					sw_state_d = SW_WAIT_READY;
				end
			end
			SW_WAIT_READY: begin
				if (new_ready) begin
					sw_state_d = SW_COUNT;
				end
			end
			SW_COUNT: begin
				if (sw_done) begin
					sw_state_d = SW_IDLE;
				end
			end
			default: begin
				sw_state_d = SW_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_state_q <= SW_IDLE;
			tick_cnt_q <= '0;
		end else begin
			sw_state_q <= sw_state_d;
			if (sw_state_q != SW_COUNT) begin
				tick_cnt_q <= '0;
			end else if (new_clk_rise) begin
				tick_cnt_q <= tick_cnt_q + 4'h1;
			end
		end
	end

	// control register; power-on reset only, config caught one edge after release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_load_q <= 1'b1;
			cfg_q <= '0;
			cur_src_q <= clock_select_pkg::SRC_FAST_RC_DIV_N;
			new_src_q <= clock_select_pkg::SRC_FAST_RC_DIV_N;
			cfg_lock_q <= 1'b0;
			fail_q <= 1'b0;
			sec_en_q <= 1'b0;
			switch_q <= 1'b0;
		end else if (cfg_load_q) begin
			cfg_load_q <= 1'b0;
			cfg_q <= cfg_bits;
			cur_src_q <= cfg_bits.initial_source_cfg;
			new_src_q <= cfg_bits.initial_source_cfg;
		end else begin
			if (osc_hi_wr && !cfg_locked && sw_state_q == SW_IDLE) begin
				new_src_q <= wdata_q[clock_select_pkg::OSC_NEW_LSB +: 3];
			end
			if (osc_lo_wr) begin
				cfg_lock_q <= wdata_q[clock_select_pkg::OSC_LOCK_BIT];
				sec_en_q <= wdata_q[clock_select_pkg::OSC_SEC_EN_BIT];
			end
			// failure set wins over software and switch-start clears
			if (fail_rise) begin
				fail_q <= 1'b1;
			end else if ((osc_lo_wr && !wdata_q[clock_select_pkg::OSC_FAIL_BIT])
				|| (sw_start && !req_same)) begin
				fail_q <= 1'b0;
			end
			if (!switching_on || sw_abort || sw_done) begin
				switch_q <= 1'b0;
			end else if (osc_lo_wr && !cfg_locked && wdata_q[clock_select_pkg::OSC_SWITCH_BIT]) begin
				switch_q <= 1'b1;
			end
			if (sw_done) begin
				cur_src_q <= new_src_q;
			end
		end
	end

	// divisor and feedback registers
	wire div_hi_wr = wr_div && wstrb_q[1];
	wire div_lo_wr = wr_div && wstrb_q[0] && !cfg_locked;
	wire [1:0] post_wr = wdata_q[clock_select_pkg::DIV_POST_LSB +: 2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			roi_q <= 1'b0;
			doze_q <= clock_select_pkg::DOZE_RESET;
			reduction_enable_q <= 1'b0;
			rc_div_q <= clock_select_pkg::RC_DIV_RESET;
			post_q <= clock_select_pkg::POST_RESET;
			pre_q <= clock_select_pkg::PRE_RESET;
			fbd_q <= clock_select_pkg::FBD_RESET;
		end else begin
			if (div_hi_wr) begin
				roi_q <= wdata_q[clock_select_pkg::DIV_ROI_BIT];
				doze_q <= wdata_q[clock_select_pkg::DIV_DOZE_LSB +: 3];
				rc_div_q <= wdata_q[clock_select_pkg::DIV_RC_LSB +: 3];
			end
			// interrupt recovery beats a concurrent software set
			if (roi_q && interrupt_event) begin
				reduction_enable_q <= 1'b0;
			end else if (div_hi_wr) begin
				reduction_enable_q <= wdata_q[clock_select_pkg::DIV_REDUCTION_ENABLE_BIT];
			end
			if (div_lo_wr) begin
				pre_q <= wdata_q[clock_select_pkg::DIV_PRE_LSB +: 5];
				if (post_wr != clock_select_pkg::POST_RESERVED) begin
					post_q <= post_wr;
				end
			end
			if (wr_fbd && !cfg_locked && wstrb_q != 2'b00) begin
				fbd_q <= {wstrb_q[1] ? wdata_q[8] : fbd_q[8], wstrb_q[0] ? wdata_q[7:0] : fbd_q[7:0]};
			end
		end
	end

	// pll factors: fout = fin * m / (n1 * n2)
	assign pll_cfg.in_divide = {1'b0, pre_q} + clock_select_pkg::PRE_OFFSET;
	assign pll_cfg.feedback_mult = {1'b0, fbd_q} + clock_select_pkg::FBD_OFFSET;
	assign pll_cfg.out_divide = post_q == 2'h3 ? 4'h8 : 4'h2 << post_q;
	assign pll_enable = pll_src || (sw_state_q != SW_IDLE && new_is_pll);
	assign current_source_sel = cur_src_q;
	assign primary_mode = cfg_load_q ? clock_select_pkg::PRIM_NONE
		: clock_select_pkg::primary_e'(cfg_q.primary_submode_cfg);
	assign osc_pin_is_io = cfg_q.osc_pin_function_cfg;
	assign secondary_osc_enable = sec_en_q;

	// core enable every second oscillator cycle
	logic core_cnt_q;
	logic [6:0] doze_cnt_q;
	logic [6:0] doze_top_q;
	logic [7:0] rc_cnt_q;
	logic [7:0] rc_top_q;
	wire core_tick = core_cnt_q == 1'(clock_select_pkg::CORE_DIVIDE - 2'h1);
	wire [6:0] doze_top_d = reduction_enable_q ? 7'((8'h01 << doze_q) - 8'h01) : 7'h00;
	wire [8:0] rc_shift = rc_div_q == clock_select_pkg::RC_DIV_MAX_CODE
		? clock_select_pkg::RC_DIV_MAX_SHIFT : {6'h00, rc_div_q};
	wire [7:0] rc_top_d = 8'((9'h001 << rc_shift) - 9'h001);
	wire doze_wrap = doze_cnt_q >= doze_top_q;
	wire rc_wrap = rc_cnt_q >= rc_top_q;

	// new ratios only take effect at a period boundary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_cnt_q <= 1'b0;
			doze_cnt_q <= '0;
			doze_top_q <= '0;
			rc_cnt_q <= '0;
			rc_top_q <= '0;
			cpu_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
			rc_div_clk_en <= 1'b0;
		end else begin
			core_cnt_q <= core_tick ? 1'b0 : core_cnt_q + 1'b1;
			periph_clk_en <= core_tick;
			cpu_clk_en <= core_tick && doze_wrap;
			if (core_tick) begin
				doze_cnt_q <= doze_wrap ? 7'h00 : doze_cnt_q + 7'h01;
				if (doze_wrap) begin
					doze_top_q <= doze_top_d;
				end
			end
			rc_cnt_q <= rc_wrap ? 8'h00 : rc_cnt_q + 8'h01;
			rc_div_clk_en <= rc_wrap;
			if (rc_wrap) begin
				rc_top_q <= rc_top_d;
			end
		end
	end

endmodule : clock_select

// ===== tb/clock_select_checker.sv
/*
 * clock_select_checker: concurrent checks on the ports of clock_select.
 * Assumes it is bound to clock_select, one clock aclk, aresetn active low.
 */
`timescale 1ns/1ps
module clock_select_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire clock_select_pkg::cfg_bits_s cfg_bits,
	input wire logic [2:0] current_source_sel,
	input wire clock_select_pkg::primary_e primary_mode,
	input wire logic osc_pin_is_io,
	input wire clock_select_pkg::pll_cfg_s pll_cfg,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after acceptance");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data held after acceptance");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	periph_rate_a: assert property (periph_clk_en |=> !periph_clk_en ##1 periph_clk_en)
		else $error("peripheral enable not every second cycle");
	cpu_sub_a: assert property (cpu_clk_en |-> periph_clk_en)
		else $error("processor enable off the peripheral grid");
	prim_cfg_a: assert property ($past(aresetn, 2) |-> primary_mode == cfg_bits.primary_submode_cfg)
		else $error("primary submode differs from strap");
	pin_cfg_a: assert property ($past(aresetn, 2) |-> osc_pin_is_io == cfg_bits.osc_pin_function_cfg)
		else $error("pin function differs from strap");
	pre_range_a: assert property (pll_cfg.in_divide inside {[6'h02:6'h21]})
		else $error("input divide out of range");
	post_code_a: assert property (pll_cfg.out_divide inside {4'h2, 4'h4, 4'h8})
		else $error("output divide not 2, 4 or 8");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (periph_clk_en && !cpu_clk_en);
	cover property (current_source_sel == 3'h1);
endmodule : clock_select_checker

// ===== tb/tb_top.sv
/*
 * tb_top: self-checking bench of clock_select over AXI4-Lite against an integer model.
 * Assumes the package, design and checker are compiled before this file.
 */
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] CTRL_A = clock_select_pkg::OFS_OSC_CTRL;
	localparam logic [7:0] DIV_A = clock_select_pkg::OFS_CLK_DIV;
	localparam logic [7:0] FBD_A = clock_select_pkg::OFS_PLL_FBD;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	// div-n start, hs crystal, switching on, lock honoured, pin as io
	clock_select_pkg::cfg_bits_s cfg_bits = 8'hF3;
	logic new_source_clk = 1'b0, pll_locked_pin = 1'b0, clock_fail_pin = 1'b0;
	logic interrupt_event = 1'b0;
	logic [2:0] current_source_sel;
	clock_select_pkg::primary_e primary_mode;
	clock_select_pkg::pll_cfg_s pll_cfg;
	logic osc_pin_is_io, secondary_osc_enable, pll_enable;
	logic cpu_clk_en, periph_clk_en, rc_div_clk_en;
	logic [15:0] rnd = 16'h660B;
	int miscompares = 0;
	int samples_checked = 0;

	always #12.5 aclk = ~aclk;

	clock_select i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .cfg_bits(cfg_bits), .source_ready(8'hFF),
		.new_source_clk(new_source_clk), .pll_locked_pin(pll_locked_pin),
		.clock_fail_pin(clock_fail_pin), .interrupt_event(interrupt_event),
		.current_source_sel(current_source_sel), .primary_mode(primary_mode),
		.osc_pin_is_io(osc_pin_is_io), .secondary_osc_enable(secondary_osc_enable),
		.pll_enable(pll_enable), .pll_cfg(pll_cfg), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .rc_div_clk_en(rc_div_clk_en)
	);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [31:0] osc(input int c, input int n, input logic [7:0] f);
		return {16'h0, 1'b0, c[2:0], 1'b0, n[2:0], f};
	endfunction : osc

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_data

	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_resp

	task automatic stuck;
		check_data(32'h0, 32'h1);
		conclude();
	endtask : stuck

	// handshakes seen at the falling edge; inputs move after rising edges
	task automatic wchk(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
		logic ah, wh, bh;
		logic [1:0] r;
		bh = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 100 && !bh; n++) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (!bh) stuck();
		check_resp(r, e);
	endtask : wchk

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		rh = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 100 && !rh; n++) begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!rh) stuck();
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check_data(d, e);
		check_resp(r, er);
	endtask : rchk

	// every control write needs its own key pair
	task automatic cwr(input logic [15:0] d);
		wchk(8'h0C, clock_select_pkg::UNLOCK_KEY_A, 2'h0);
		wchk(8'h0C, clock_select_pkg::UNLOCK_KEY_B, 2'h0);
		wchk(CTRL_A, d, 2'h0);
	endtask : cwr

	task automatic wait_sw;
		logic [31:0] d;
		logic [1:0] r;
		d = 32'h1;
		for (int n = 0; n < 40 && d[0]; n++) begin
			rd(CTRL_A, d, r);
		end
		if (d[0]) stuck();
	endtask : wait_sw

	// slow source clock, eight aclk per period, still between bursts
	task automatic edges(input int k);
		repeat (k) begin
			repeat (4) @(posedge aclk);
			new_source_clk <= 1'b1;
			repeat (4) @(posedge aclk);
			new_source_clk <= 1'b0;
		end
	endtask : edges

	task automatic irq;
		@(posedge aclk);
		interrupt_event <= 1'b1;
		@(posedge aclk);
		interrupt_event <= 1'b0;
	endtask : irq

	// gap between the last two of four pulses, so a ratio change has settled
	task automatic period(input logic rc, input int e);
		int gap;
		int n;
		n = 0;
		repeat (4) begin
			gap = 0;
			do begin
				@(negedge aclk);
				gap++;
				n++;
			end while (!(rc ? rc_div_clk_en : cpu_clk_en) && n < 3000);
		end
		if (n >= 3000) stuck();
		check_data(gap, e);
	endtask : period

	initial begin
		logic [15:0] d, e;
		logic [1:0] keep;
		keep = 2'h1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk(CTRL_A, osc(7, 7, 8'h00), 2'h0);
		rchk(DIV_A, 32'h3040, 2'h0);
		rchk(FBD_A, 32'h0030, 2'h0);
		check_data({29'h0, current_source_sel}, 32'h7);
		check_data({30'h0, primary_mode}, 32'h2);
		check_data({31'h0, osc_pin_is_io}, 32'h1);
		$display("test reset values done");
		wchk(8'h10, 16'hFFFF, 2'h3);
		rchk(8'h10, 32'h0, 2'h3);
		wchk(CTRL_A, 16'h0002, 2'h0);
		wchk(8'h0C, clock_select_pkg::UNLOCK_KEY_A, 2'h0);
		wchk(DIV_A, 16'h3040, 2'h0);
		wchk(8'h0C, clock_select_pkg::UNLOCK_KEY_B, 2'h0);
		wchk(CTRL_A, 16'h0002, 2'h0);
		rchk(CTRL_A, osc(7, 7, 8'h00), 2'h0);
		$display("test refusals done");
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			d = {rnd[15:8], i[1:0], rnd[5:0]};
			e = d & 16'hFFDF;
			if (i == 2) e[7:6] = keep;
			keep = e[7:6];
			wchk(DIV_A, d, 2'h0);
			rchk(DIV_A, {16'h0, e}, 2'h0);
			check_data(pll_cfg.in_divide, e[4:0] + 32'h2);
			check_data(pll_cfg.out_divide, (e[7:6] == 2'h3) ? 32'h8 : 32'h2 << e[7:6]);
			rnd = lfsr(rnd);
			wchk(FBD_A, rnd, 2'h0);
			rchk(FBD_A, {23'h0, rnd[8:0]}, 2'h0);
			check_data(pll_cfg.feedback_mult, rnd[8:0] + 32'h2);
		end
		wchk(DIV_A, 16'h2B40, 2'h0);
		period(1'b0, 8);
		period(1'b1, 8);
		wchk(DIV_A, 16'h0740, 2'h0);
		period(1'b0, 2);
		period(1'b1, 256);
		wchk(DIV_A, 16'h8840, 2'h0);
		irq();
		rchk(DIV_A, 32'h8040, 2'h0);
		wchk(DIV_A, 16'h0840, 2'h0);
		irq();
		rchk(DIV_A, 32'h0840, 2'h0);
		$display("test divisor done");
		cwr(16'h0002);
		rchk(CTRL_A, osc(7, 0, 8'h02), 2'h0);
		check_data({31'h0, secondary_osc_enable}, 32'h1);
		cwr(16'h0003);
		edges(9);
		repeat (8) @(posedge aclk);
		rchk(CTRL_A, osc(7, 0, 8'h03), 2'h0);
		edges(1);
		wait_sw();
		rchk(CTRL_A, osc(0, 0, 8'h02), 2'h0);
		check_data({29'h0, current_source_sel}, 32'h0);
		cwr(16'h0003);
		rchk(CTRL_A, osc(0, 0, 8'h02), 2'h0);
		$display("test switch done");
		cwr(16'h0103);
		@(negedge aclk);
		check_data({31'h0, pll_enable}, 32'h1);
		edges(10);
		repeat (8) @(posedge aclk);
		rchk(CTRL_A, osc(0, 1, 8'h03), 2'h0);
		pll_locked_pin <= 1'b1;
		edges(10);
		wait_sw();
		rchk(CTRL_A, osc(1, 1, 8'h22), 2'h0);
		check_data({29'h0, current_source_sel}, 32'h1);
		$display("test pll switch done");
		clock_fail_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		rchk(CTRL_A, osc(1, 1, 8'h2A), 2'h0);
		clock_fail_pin <= 1'b0;
		cwr(16'h0102);
		rchk(CTRL_A, osc(1, 1, 8'h22), 2'h0);
		cwr(16'h010A);
		rchk(CTRL_A, osc(1, 1, 8'h22), 2'h0);
		$display("test clock fail done");
		cwr(16'h0182);
		rchk(CTRL_A, osc(1, 1, 8'hA2), 2'h0);
		cwr(16'h0083);
		rchk(CTRL_A, osc(1, 1, 8'hA2), 2'h0);
		wchk(DIV_A, 16'h08C5, 2'h0);
		rchk(DIV_A, 32'h0840, 2'h0);
		$display("test lock done");
		conclude();
	end
endmodule : tb_top

bind clock_select clock_select_checker i_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.cfg_bits(cfg_bits), .current_source_sel(current_source_sel),
	.primary_mode(primary_mode), .osc_pin_is_io(osc_pin_is_io), .pll_cfg(pll_cfg),
	.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en)
);
